// >>> common/flash_pkg.sv
/*
  Shared constants, types and register map for the flash command and
  protection controller. Assumes a 16-bit flash address space split into
  512-byte pages and an 8-bit register file on a 32-bit Avalon-MM slave.
*/
`default_nettype none
package flash_pkg;
  localparam int ADDR_W = 16;
  localparam int PAGE_SHIFT = 9;
  localparam int SEL_W = ADDR_W - PAGE_SHIFT;

  // register byte offsets
  localparam logic [7:0] OFS_PROT = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_CDIV = 8'h0C;
  localparam logic [7:0] OFS_ADDR = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;
  localparam logic [7:0] OFS_SEC = 8'h18;

  // status bit positions
  localparam int STAT_CBEF = 7;
  localparam int STAT_CCF = 6;
  localparam int STAT_PVIOL = 5;
  localparam int STAT_ACCERR = 4;
  localparam int STAT_BLANK = 2;

  // protection and divider fields
  localparam int PROT_DIS = 0;
  localparam int CDIV_LOADED = 7;
  localparam int CDIV_PRESCALE_BY_EIGHT = 6;
  localparam logic [7:0] CDIV_RESET = 8'h00;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [1:0] SEC_UNSECURED = 2'b10;

  // command codes
  localparam logic [7:0] CMD_BLANK = 8'h05;
  localparam logic [7:0] CMD_BYTE = 8'h20;
  localparam logic [7:0] CMD_BURST = 8'h25;
  localparam logic [7:0] CMD_PAGE = 8'h40;
  localparam logic [7:0] CMD_MASS = 8'h41;

  typedef struct packed {
    logic [7:0] code;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } cmd_s;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_DATA = 3'b010,
    SEQ_CMD = 3'b100
  } seq_e;

  typedef enum logic [1:0] {
    EX_IDLE = 2'b01,
    EX_RUN = 2'b10
  } exec_e;
endpackage
`default_nettype wire

// >>> rtl/flash_clk_div.sv
/*
  Flash clock divider: one tick every (div+1) bus cycles, or every
  8*(div+1) with the prescaler. Assumes run is held for a whole command.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_clk_div (
  input wire logic clock,
  input wire logic rst,
  input wire logic [5:0] div,
  input wire logic prescale_by_eight,
  input wire logic run,
  output logic tick
);
  import flash_pkg::*;

  logic [8:0] cnt_q;
  logic [8:0] limit;

  assign limit = prescale_by_eight ? {div, 3'b111} : {3'b000, div};

  always_ff @(posedge clock) begin
    if (rst || !run) begin
      cnt_q <= 9'h000;
    end else if (cnt_q >= limit) begin
      cnt_q <= 9'h000;
    end else begin
      cnt_q <= cnt_q + 9'h001;
    end
  end

  // counter restarts with each run so the first tick lands a full period in
  assign tick = run && (cnt_q == limit);

  property p_tick_gap;
    @(posedge clock) disable iff (rst)
      (tick && run && limit != 9'h000 && $stable(limit)) |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("flash tick repeated too soon");
endmodule
`default_nettype wire

// >>> rtl/flash_cmd_exec.sv
/*
  Runs one command against the flash array: holds the request, forwards
  flash clock pulses, ends on the array's acknowledge. Assumes the array
  answers with arr_ack and reports arr_erased with it for blank checks.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_cmd_exec (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire flash_pkg::cmd_s cmd,
  input wire logic abort,
  input wire logic tick,
  input wire logic arr_ack,
  input wire logic arr_erased,
  output logic busy,
  output logic done,
  output logic blank_ok,
  output logic arr_valid,
  output flash_pkg::cmd_s arr_cmd,
  output logic arr_pulse
);
  import flash_pkg::*;

  exec_e state_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_q <= EX_IDLE;
    end else begin
      case (state_q)
        EX_IDLE: begin
          if (start) begin
            state_q <= EX_RUN;
          end
        end
        EX_RUN: begin
          if (abort || arr_ack) begin
            state_q <= EX_IDLE;
          end
        end
        default: state_q <= EX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      arr_cmd <= '0;
    end else if (start && state_q == EX_IDLE) begin
      arr_cmd <= cmd;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      done <= 1'b0;
      blank_ok <= 1'b0;
    end else begin
      done <= (state_q == EX_RUN) && arr_ack && !abort;
      if (state_q == EX_RUN && arr_ack) begin
        blank_ok <= arr_erased;
      end
    end
  end

  assign busy = (state_q == EX_RUN);
  assign arr_valid = busy;
  assign arr_pulse = busy && tick;

  property p_abort_stops;
    @(posedge clock) disable iff (rst) (busy && abort) |=> !busy && !done;
  endproperty
  a_abort_stops: assert property (p_abort_stops) else $error("aborted command kept running");

  property p_done_once;
    @(posedge clock) disable iff (rst) done |=> !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("completion pulse longer than one cycle");
endmodule
`default_nettype wire

// >>> rtl/flash_command_protect_ctrl.sv
/*
  Flash command and protection controller: Avalon-MM register file,
  command sequence checks, protection check, one-deep burst buffer and
  security update. Assumes the flash array and nonvolatile bytes are on
  the same clock; stop and debug inputs come from logic on this clock.
*/
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ns
`default_nettype none
module flash_command_protect_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] nonvolatile_protection_byte,
  input wire logic [1:0] nonvolatile_security,
  input wire logic debug_prot_we,
  input wire logic [7:0] debug_prot_data,
  input wire logic stop_mode,
  input wire logic arr_ack,
  input wire logic arr_erased,
  output logic arr_valid,
  output flash_pkg::cmd_s arr_cmd,
  output logic arr_pulse,
  output logic [7:0] protection_reg,
  output logic [1:0] security_code
);
  import flash_pkg::*;

  logic ack_q;
  logic [31:0] readdata_q;
  logic [7:0] prot_q;
  logic [7:0] cdiv_q;
  logic [7:0] cmd_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0] data_q;
  logic [1:0] sec_q;
  logic pviol_q;
  logic accerr_q;
  logic blank_q;
  logic pending_q;
  cmd_s pend_q;
  seq_e seq_q;
  logic [7:0] wd;
  logic wr;
  logic wr_prot, wr_stat, wr_cmd, wr_cdiv, wr_addr, wr_data;
  logic buffer_empty_flag, command_complete_flag;
  logic exec_busy, exec_done, blank_ok, tick, xfer;
  logic launch_wr, legal, prog_erase, protected_hit;
  logic seq_err, launch_err, pviol_set, launch_ok, stop_abort;
  logic [7:0] stat_rd;
  logic [7:0] rd_byte;

  // one wait state on every access; read data are registered meanwhile
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end
  assign waitrequest = (read || write) && !ack_q;

  assign wd = writedata[7:0];
  assign wr = write && ack_q && byteenable[0];
  assign wr_prot = wr && (address == OFS_PROT);
  assign wr_stat = wr && (address == OFS_STAT);
  assign wr_cmd = wr && (address == OFS_CMD);
  assign wr_cdiv = wr && (address == OFS_CDIV);
  assign wr_addr = wr && (address == OFS_ADDR);
  assign wr_data = wr && (address == OFS_DATA);

  // buffer and completion state follow the queue, so no flag can disagree
  assign buffer_empty_flag = !pending_q && !(exec_busy && arr_cmd.code != CMD_BURST);
  // held low through the done cycle so the blank flag is settled when it rises
  assign command_complete_flag = !pending_q && !exec_busy && !exec_done;

  assign legal = (cmd_q == CMD_BLANK) || (cmd_q == CMD_BYTE) || (cmd_q == CMD_BURST)
      || (cmd_q == CMD_PAGE) || (cmd_q == CMD_MASS);
  assign prog_erase = legal && (cmd_q != CMD_BLANK);
  // mass erase touches every page, so any protection blocks it
  assign protected_hit = !prot_q[PROT_DIS] && ((cmd_q == CMD_MASS)
      || (addr_q[ADDR_W-1:PAGE_SHIFT] > prot_q[7:1]));

  assign launch_wr = wr_stat && wd[STAT_CBEF] && buffer_empty_flag;
  assign seq_err = (wr_cmd && seq_q != SEQ_DATA) || (wr_data && seq_q == SEQ_CMD);
  assign launch_err = launch_wr && ((seq_q != SEQ_CMD) || !legal
      || (prog_erase && !cdiv_q[CDIV_LOADED])
      || (exec_busy && (cmd_q != CMD_BURST || arr_cmd.code != CMD_BURST)));
  assign pviol_set = launch_wr && !launch_err && prog_erase && protected_hit;
  assign launch_ok = launch_wr && !launch_err && !pviol_set;
  assign stop_abort = stop_mode && (exec_busy || pending_q);
  assign xfer = pending_q && !exec_busy && !stop_mode;

  always_ff @(posedge clock) begin
    if (rst) begin
      seq_q <= SEQ_IDLE;
    end else if (seq_err || launch_wr || stop_abort) begin
      seq_q <= SEQ_IDLE;
    end else begin
      case (seq_q)
        SEQ_IDLE: begin
          if (wr_data) begin
            seq_q <= SEQ_DATA;
          end
        end
        SEQ_DATA: begin
          if (wr_cmd) begin
            seq_q <= SEQ_CMD;
          end
        end
        SEQ_CMD: seq_q <= SEQ_CMD;
        default: seq_q <= SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cmd_q <= CMD_RESET;
      addr_q <= '0;
      data_q <= 8'h00;
    end else begin
      if (wr_cmd) begin
        cmd_q <= wd;
      end
      if (wr_addr) begin
        addr_q <= writedata[ADDR_W-1:0];
      end
      if (wr_data) begin
        data_q <= wd;
      end
    end
  end

  // one-deep buffer; a burst moves on as soon as the array is free
  always_ff @(posedge clock) begin
    if (rst || stop_abort) begin
      pending_q <= 1'b0;
      pend_q <= '0;
    end else if (launch_ok) begin
      pending_q <= 1'b1;
      pend_q <= '{code: cmd_q, addr: addr_q, data: data_q};
    end else if (xfer) begin
      pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cdiv_q <= CDIV_RESET;
    end else if (wr_cdiv) begin
      cdiv_q <= {1'b1, wd[6:0]};
    end
  end

  // nonvolatile copy is taken on every reset cycle, not only at power-up
  always_ff @(posedge clock) begin
    if (rst) begin
      prot_q <= nonvolatile_protection_byte;
    end else if (debug_prot_we) begin
      prot_q <= debug_prot_data;
    end else if (wr_prot && !prot_q[PROT_DIS] && wd[7:1] < prot_q[7:1]) begin
      prot_q[7:1] <= wd[7:1];
    end
  end

  // a set in the same cycle as a software clear wins
  always_ff @(posedge clock) begin
    if (rst) begin
      pviol_q <= 1'b0;
      accerr_q <= 1'b0;
    end else begin
      pviol_q <= pviol_set || (pviol_q && !(wr_stat && wd[STAT_PVIOL]));
      accerr_q <= seq_err || launch_err || stop_abort
          || (accerr_q && !(wr_stat && wd[STAT_ACCERR]));
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      blank_q <= 1'b0;
      sec_q <= nonvolatile_security;
    end else begin
      if (exec_done && arr_cmd.code == CMD_BLANK && blank_ok) begin
        blank_q <= 1'b1;
        sec_q <= SEC_UNSECURED;
      end else if (launch_ok) begin
        blank_q <= 1'b0;
      end
    end
  end

  assign stat_rd = {buffer_empty_flag, command_complete_flag, pviol_q, accerr_q, 1'b0, blank_q, 2'b00};

  always_comb begin
    case (address)
      OFS_PROT: rd_byte = prot_q;
      OFS_STAT: rd_byte = stat_rd;
      OFS_CMD: rd_byte = cmd_q;
      OFS_CDIV: rd_byte = cdiv_q;
      OFS_DATA: rd_byte = data_q;
      OFS_SEC: rd_byte = {6'h00, sec_q};
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata_q <= 32'h00000000;
    end else if (read && !ack_q) begin
      if (address == OFS_ADDR) begin
        readdata_q <= {16'h0000, addr_q};
      end else begin
        readdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  assign readdata = readdata_q;
  assign protection_reg = prot_q;
  assign security_code = sec_q;

  flash_clk_div u_div (
    .clock(clock),
    .rst(rst),
    .div(cdiv_q[5:0]),
    .prescale_by_eight(cdiv_q[CDIV_PRESCALE_BY_EIGHT]),
    .run(exec_busy),
    .tick(tick)
  );

  flash_cmd_exec u_exec (
    .clock(clock),
    .rst(rst),
    .start(xfer),
    .cmd(pend_q),
    .abort(stop_abort),
    .tick(tick),
    .arr_ack(arr_ack),
    .arr_erased(arr_erased),
    .busy(exec_busy),
    .done(exec_done),
    .blank_ok(blank_ok),
    .arr_valid(arr_valid),
    .arr_cmd(arr_cmd),
    .arr_pulse(arr_pulse)
  );

  property p_prot_guard;
    @(posedge clock) disable iff (rst)
      ($changed(prot_q) && !$past(debug_prot_we)) |->
        $past(wr_prot) && !$past(prot_q[PROT_DIS]) && (prot_q[7:1] < $past(prot_q[7:1]));
  endproperty
  a_prot_guard: assert property (p_prot_guard) else $error("protection weakened by write");

  property p_launch_busy;
    @(posedge clock) disable iff (rst) launch_ok |=> !buffer_empty_flag && !command_complete_flag;
  endproperty
  a_launch_busy: assert property (p_launch_busy) else $error("flags not cleared by launch");

  property p_pviol;
    @(posedge clock) disable iff (rst) pviol_set |=> pviol_q && !pending_q;
  endproperty
  a_pviol: assert property (p_pviol) else $error("protected command not discarded");

  property p_accerr_hold;
    @(posedge clock) disable iff (rst)
      (accerr_q && !(wr_stat && wd[STAT_ACCERR])) |=> accerr_q;
  endproperty
  a_accerr_hold: assert property (p_accerr_hold) else $error("access error cleared without write");

  property p_illegal;
    @(posedge clock) disable iff (rst)
      (launch_wr && seq_q == SEQ_CMD && !legal) |=>
        accerr_q && !pending_q && ($past(exec_busy) || !exec_busy);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal code not rejected");

  property p_blank_unlock;
    @(posedge clock) disable iff (rst)
      (exec_done && arr_cmd.code == CMD_BLANK && blank_ok) |=>
        blank_q && security_code == SEC_UNSECURED;
  endproperty
  a_blank_unlock: assert property (p_blank_unlock) else $error("blank check did not unsecure");

  property p_stop_abort;
    @(posedge clock) disable iff (rst) stop_abort |=> accerr_q && !exec_busy && !pending_q;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort command");

  property p_burst_refill;
    @(posedge clock) disable iff (rst)
      (xfer && pend_q.code == CMD_BURST) |=> buffer_empty_flag ##1 (buffer_empty_flag || pending_q);
  endproperty
  a_burst_refill: assert property (p_burst_refill) else $error("burst transfer kept buffer full");

  c_launch: cover property (@(posedge clock) disable iff (rst) launch_ok);
  c_burst_queued: cover property (@(posedge clock) disable iff (rst) launch_ok && exec_busy);
  c_blank_pass: cover property (@(posedge clock) disable iff (rst)
      exec_done && arr_cmd.code == CMD_BLANK && blank_ok);
  c_pviol: cover property (@(posedge clock) disable iff (rst) pviol_set);
endmodule
`default_nettype wire

// >>> tb/flash_array_model.sv
/*
  Flash array stand-in: acknowledges a running command after a set number
  of flash clock pulses and reports the blank result with the acknowledge.
  Assumes the controller holds arr_valid for the whole operation.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_array_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic arr_valid,
  input wire logic arr_pulse,
  input wire logic [3:0] pulses_needed,
  input wire logic array_blank,
  output logic arr_ack,
  output logic arr_erased
);
  logic [3:0] cnt_q;
  logic junk_q;
  always_ff @(posedge clock) begin
    if (rst || !arr_valid || arr_ack) begin
      cnt_q <= 4'h0;
      arr_ack <= 1'b0;
    end else if (arr_pulse) begin
      cnt_q <= cnt_q + 4'h1;
      arr_ack <= (cnt_q + 4'h1 >= pulses_needed);
    end
  end
  // result only means something with the acknowledge; toggle otherwise
  always_ff @(posedge clock) begin
    if (rst)
      junk_q <= 1'b0;
    else
      junk_q <= ~junk_q;
  end
  assign arr_erased = arr_ack ? array_blank : junk_q;
endmodule
`default_nettype wire

// >>> tb/flash_command_protect_ctrl_test.sv
/*
  Self-checking bench for the flash command and protection controller.
  Assumes the package register map and one-wait-state bus answer.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_command_protect_ctrl_test;
  import flash_pkg::*;
  logic clock, rst, read, write, debug_prot_we, stop_mode, waitrequest;
  logic arr_ack, arr_erased, arr_valid, arr_pulse, array_blank, valid_d, ack_d;
  logic m_pviol, m_accerr, m_blank, cdiv_ok;
  logic [7:0] address, nv_prot, debug_prot_data, protection_reg, m_prot;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] pulses;
  logic [1:0] nv_sec, security_code, m_sec;
  logic [15:0] rnd;
  cmd_s arr_cmd;
  cmd_s seen[$];
  int err_count, n_compared, cyc, last_p, gap;
  logic [7:0] codes [7] = '{CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS, 8'h33, CMD_BLANK};

  flash_command_protect_ctrl uut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .nonvolatile_protection_byte(nv_prot),
    .nonvolatile_security(nv_sec), .debug_prot_we(debug_prot_we),
    .debug_prot_data(debug_prot_data), .stop_mode(stop_mode), .arr_ack(arr_ack),
    .arr_erased(arr_erased), .arr_valid(arr_valid), .arr_cmd(arr_cmd),
    .arr_pulse(arr_pulse), .protection_reg(protection_reg), .security_code(security_code));

  flash_array_model array (.clock(clock), .rst(rst), .arr_valid(arr_valid),
    .arr_pulse(arr_pulse), .pulses_needed(pulses), .array_blank(array_blank),
    .arr_ack(arr_ack), .arr_erased(arr_erased));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // a queued operation starts one idle cycle after an ack; capture on ack too
  always @(posedge clock) begin
    cyc <= cyc + 1;
    valid_d <= arr_valid;
    ack_d <= arr_ack;
    if (arr_valid === 1'b1 && (valid_d !== 1'b1 || ack_d === 1'b1))
      seen.push_back(arr_cmd);
    if (arr_valid !== 1'b1 || ack_d === 1'b1)
      last_p <= -1;
    else if (arr_pulse === 1'b1) begin
      if (last_p >= 0)
        chk(32'(cyc - last_p), 32'(gap));
      last_p <= cyc;
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic logic [7:0] stat_exp();
    return {2'b11, m_pviol, m_accerr, 1'b0, m_blank, 2'b00};
  endfunction

  // 0 runs, 1 access error, 2 protection violation
  function automatic int outcome(input logic [7:0] c, input logic [15:0] a);
    if (!(c inside {CMD_BLANK, CMD_BYTE, CMD_BURST, CMD_PAGE, CMD_MASS}))
      return 1;
    if (c == CMD_BLANK)
      return 0;
    if (!cdiv_ok)
      return 1;
    if (!m_prot[0] && (c == CMD_MASS || a[15:9] > m_prot[7:1]))
      return 2;
    return 0;
  endfunction

  task automatic bus(input bit wr, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= {16'h0000, d};
    write <= wr;
    read <= !wr;
    // looked at in the edge's own time step, before the design's updates land
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      err_count++;
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic issue(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, OFS_ADDR, a);
    bus(1'b1, OFS_DATA, {8'h00, d});
    bus(1'b1, OFS_CMD, {8'h00, c});
    bus(1'b1, OFS_STAT, 16'h0080);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STAT, 16'h0000);
      n++;
    end while (rd[6] !== 1'b1 && n < 100);
    bus(1'b0, OFS_STAT, 16'h0000);
  endtask

  task automatic do_cmd(input logic [7:0] c, input logic [15:0] a);
    logic [7:0] d;
    int o;
    d = rnd[7:0];
    o = outcome(c, a);
    pulses <= {2'b00, rnd[9:8]} + 4'h1;
    rnd = lfsr(rnd);
    issue(c, a, d);
    wait_idle();
    chk(seen.size(), (o == 0) ? 1 : 0);
    if (o == 0 && seen.size() == 1)
      chk(seen.pop_front(), {c, a, d});
    seen.delete();
    if (o == 0)
      m_blank = (c == CMD_BLANK) && array_blank;
    if (o == 0 && m_blank)
      m_sec = SEC_UNSECURED;
    m_pviol |= (o == 2);
    m_accerr |= (o == 1);
    // blank bit is left open for discarded launches
    chk(rd[7:0] | (o ? 8'h04 : 8'h00), stat_exp() | (o ? 8'h04 : 8'h00));
    chk(security_code, m_sec);
  endtask

  task automatic set_prot(input logic [7:0] w);
    bus(1'b1, OFS_PROT, {8'h00, w});
    if (!m_prot[0] && w[7:1] < m_prot[7:1])
      m_prot = {w[7:1], 1'b0};
    bus(1'b0, OFS_PROT, 16'h0000);
    chk(rd[7:0], m_prot);
    chk(protection_reg, m_prot);
  endtask

  // span covers the whole sequence several times over
  initial begin
    repeat (40000) @(posedge clock);
    err_count++;
    close_out();
  end

  initial begin
    int i, n;
    {read, write, debug_prot_we, stop_mode, array_blank, valid_d, ack_d} = '0;
    {address, writedata, debug_prot_data, cyc, err_count, n_compared} = '0;
    {m_pviol, m_accerr, m_blank, cdiv_ok} = '0;
    rst = 1'b1;
    last_p = -1;
    gap = 24;
    pulses = 4'h1;
    rnd = 16'h6FF7;
    nv_prot = 8'h80;
    nv_sec = 2'b01;
    m_prot = 8'h80;
    m_sec = 2'b01;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(protection_reg, 8'h80);
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:0], stat_exp());
    bus(1'b0, 8'h40, 16'h0000);
    chk(rd, 32'h0000_0000);
    set_prot(8'h40);
    set_prot(8'h60);
    set_prot(8'h21);
    do_cmd(CMD_BYTE, 16'h0000);
    bus(1'b1, OFS_STAT, 16'h0000);
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:0] & 8'hFB, stat_exp() & 8'hFB);
    bus(1'b1, OFS_CDIV, 16'h0042);
    cdiv_ok = 1'b1;
    do_cmd(CMD_BYTE, 16'h2200);
    do_cmd(CMD_PAGE, 16'h21FF);
    do_cmd(CMD_MASS, 16'h0000);
    bus(1'b1, OFS_CMD, {8'h00, CMD_BYTE});
    m_accerr = 1'b1;
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:0] & 8'hFB, stat_exp() & 8'hFB);
    bus(1'b1, OFS_STAT, 16'h0030);
    {m_pviol, m_accerr} = 2'b00;
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:0] & 8'hFB, stat_exp() & 8'hFB);
    @(posedge clock);
    debug_prot_data <= 8'h01;
    debug_prot_we <= 1'b1;
    @(posedge clock);
    debug_prot_we <= 1'b0;
    m_prot = 8'h01;
    set_prot(8'h00);
    for (i = 0; i < 7; i++) begin
      array_blank <= (i == 6);
      do_cmd(codes[i], rnd);
    end
    bus(1'b1, OFS_CDIV, 16'h0005);
    gap = 6;
    pulses <= 4'h3;
    issue(CMD_BURST, 16'h0100, 8'hA5);
    n = 0;
    do begin
      bus(1'b0, OFS_STAT, 16'h0000);
      n++;
    end while (rd[7] !== 1'b1 && n < 30);
    chk(rd[7:6], 2'b10);
    issue(CMD_BURST, 16'h0101, 8'h5A);
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:6], 2'b00);
    wait_idle();
    chk(seen.size(), 2);
    chk(seen.pop_front(), {CMD_BURST, 16'h0100, 8'hA5});
    chk(seen.pop_front(), {CMD_BURST, 16'h0101, 8'h5A});
    pulses <= 4'h4;
    issue(CMD_BYTE, 16'h0200, 8'h11);
    n = 0;
    while (arr_valid !== 1'b1 && n < 50) begin
      @(posedge clock);
      n++;
    end
    stop_mode <= 1'b1;
    repeat (2) @(posedge clock);
    stop_mode <= 1'b0;
    @(posedge clock);
    chk(arr_valid, 1'b0);
    seen.delete();
    {m_accerr, m_blank} = 2'b10;
    wait_idle();
    chk(rd[7:0], stat_exp());
    nv_prot <= 8'h3F;
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk(protection_reg, 8'h3F);
    {m_pviol, m_accerr, m_blank} = 3'b000;
    bus(1'b0, OFS_STAT, 16'h0000);
    chk(rd[7:0], stat_exp());
    close_out();
  end
endmodule
`default_nettype wire
